// File: smbus_addr_consts.svh
// Register offsets, field positions, reset values for address match block
`ifndef SMBUS_ADDR_CONSTS_SVH
`define SMBUS_ADDR_CONSTS_SVH
`define ADDR_REG_OFFSET 8'hF4
`define MASK_REG_OFFSET 8'hF5
`define ADDR_REG_RESET 8'h00
`define MASK_REG_RESET 8'hFE
`define GC_BIT 0
`define HWACK_BIT 0
`define GENERAL_CALL_ADDR 7'h00
`endif

// File: smbus_addr_pkg.sv
// Types shared by the address match block
package smbus_addr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } phase_t;
endpackage

// File: addr_compare.sv
// Masked seven-bit address comparator with general call check
`timescale 1ns/1ps
module addr_compare #(
  parameter int ADDR_W = 7
) (
  input wire logic [ADDR_W-1:0] incoming_in,
  input wire logic [ADDR_W-1:0] own_target_address_in,
  input wire logic [ADDR_W-1:0] address_compare_mask_in,
  input wire logic general_call_enable_in,
  output logic match_out
);
  logic [ADDR_W-1:0] bit_ok;
  logic is_gc;
  // Per-bit compare, masked-off positions always agree
  genvar i;
  generate
    for (i = 0; i < ADDR_W; i++) begin : g_bit
      assign bit_ok[i] = ~address_compare_mask_in[i] |
        (incoming_in[i] == own_target_address_in[i]);
    end
  endgenerate
  assign is_gc = (incoming_in == '0) & general_call_enable_in;
  assign match_out = (&bit_ok) | is_gc;
endmodule

// File: smbus_slave_address_match.sv
// Target address register pair and hardware acknowledge decision
`timescale 1ns/1ps
`include "smbus_addr_consts.svh"
// Behaviour
// - Upper seven bits of address register hold own target address.
// - Each address bit compared only where its mask bit is one.
// - Mask zero positions are don't-care, allowing several addresses.
// - General call address accepted when general call enable set, or when masked own target address is zero.
// - Hardware ack enable set: ack matching addresses and the data bytes after them; nack the rest.
// - Hardware ack enable clear: firmware decides every acknowledge.
module smbus_slave_address_match
  import smbus_addr_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic fw_ack_valid_in,
  input wire logic fw_ack_in,
  output logic addr_match_out,
  output logic ack_valid_out,
  output logic ack_out,
  output logic fw_ack_req_out,
  output logic rw_dir_out
);
  logic [7:0] target_address_and_general_call;
  logic [7:0] target_address_mask_and_auto_ack;
  logic hardware_ack_enable;
  logic general_call_enable;
  logic [6:0] own_target_address;
  logic [6:0] address_compare_mask;
  logic cmp_match;
  logic selected;
  phase_t phase;

  assign own_target_address = target_address_and_general_call[7:1];
  assign general_call_enable = target_address_and_general_call[`GC_BIT];
  assign address_compare_mask = target_address_mask_and_auto_ack[7:1];
  assign hardware_ack_enable = target_address_mask_and_auto_ack[`HWACK_BIT];

  // Register writes; same-cycle reads see the old value
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      target_address_and_general_call <= `ADDR_REG_RESET;
      target_address_mask_and_auto_ack <= `MASK_REG_RESET;
    end else if (sfr_wr_in) begin
      if (sfr_addr_in == `ADDR_REG_OFFSET) begin
        target_address_and_general_call <= sfr_wdata_in;
      end
      if (sfr_addr_in == `MASK_REG_OFFSET) begin
        target_address_mask_and_auto_ack <= sfr_wdata_in;
      end
    end
  end

  // Registered read data, unmapped offsets read zero
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        `ADDR_REG_OFFSET: sfr_rdata_out <= target_address_and_general_call;
        `MASK_REG_OFFSET: sfr_rdata_out <= target_address_mask_and_auto_ack;
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // Direction bit excluded; only the upper seven bits compared
  addr_compare #(.ADDR_W(7)) u_cmp (
    .incoming_in(byte_in[7:1]),
    .own_target_address_in(own_target_address),
    .address_compare_mask_in(address_compare_mask),
    .general_call_enable_in(general_call_enable),
    .match_out(cmp_match)
  );

  // Transfer phase: first byte after start is the address
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase <= ST_IDLE;
      selected <= 1'b0;
      rw_dir_out <= 1'b0;
      addr_match_out <= 1'b0;
    end else if (stop_in) begin
      phase <= ST_IDLE;
      selected <= 1'b0;
      addr_match_out <= 1'b0;
    end else if (start_in) begin
      phase <= ST_ADDR;
      selected <= 1'b0;
      addr_match_out <= 1'b0;
    end else if (byte_valid_in) begin
      case (phase)
        ST_ADDR: begin
          phase <= ST_DATA;
          selected <= cmp_match;
          addr_match_out <= cmp_match;
          rw_dir_out <= byte_in[0];
        end
        ST_DATA: phase <= ST_DATA;
        default: phase <= ST_IDLE;
      endcase
    end
  end

  // Acknowledge: hardware when enabled, else firmware decides
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_valid_out <= 1'b0;
      ack_out <= 1'b0;
      fw_ack_req_out <= 1'b0;
    end else begin
      ack_valid_out <= 1'b0;
      if (start_in || stop_in) begin
        fw_ack_req_out <= 1'b0;
      end else if (byte_valid_in && phase != ST_IDLE) begin
        if (hardware_ack_enable) begin
          ack_valid_out <= 1'b1;
          ack_out <= (phase == ST_ADDR) ? cmp_match : selected;
        end else begin
          fw_ack_req_out <= 1'b1;
        end
      end else if (fw_ack_req_out && fw_ack_valid_in) begin
        fw_ack_req_out <= 1'b0;
        ack_valid_out <= 1'b1;
        ack_out <= fw_ack_in;
      end
    end
  end

  // Checks
  AST_HW_ADDR_ACK: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (byte_valid_in && phase == ST_ADDR && hardware_ack_enable &&
     !start_in && !stop_in) |=> (ack_valid_out && ack_out == $past(cmp_match)))
    else $error("address ack wrong");
  AST_NO_HW_ACK: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (byte_valid_in && phase != ST_IDLE && !hardware_ack_enable &&
     !start_in && !stop_in) |=> (fw_ack_req_out && !ack_valid_out))
    else $error("ack without firmware");
  AST_MASK_MATCH: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (((byte_in[7:1] ^ own_target_address) & address_compare_mask) == 7'h00)
    |-> cmp_match)
    else $error("masked match missed");
  AST_DONT_CARE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (address_compare_mask == 7'h00) |-> cmp_match)
    else $error("all-masked no match");
  AST_GC_IGNORE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (byte_in[7:1] == `GENERAL_CALL_ADDR && !general_call_enable &&
     ((own_target_address & address_compare_mask) != 7'h00)) |-> !cmp_match)
    else $error("general call not ignored");
  AST_GC_ACCEPT: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (byte_in[7:1] == `GENERAL_CALL_ADDR && general_call_enable) |-> cmp_match)
    else $error("general call missed");
  AST_DIR_IGNORED: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (byte_in[7:1] == own_target_address) |-> cmp_match)
    else $error("direction bit affected match");
  AST_ADDR_REG: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (sfr_wr_in && sfr_addr_in == `ADDR_REG_OFFSET) |=>
    (own_target_address == $past(sfr_wdata_in[7:1])))
    else $error("address register not written");

  // Comparator must also refuse, not only accept
  AST_MASK_MISS: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    ((((byte_in[7:1] ^ own_target_address) & address_compare_mask) != 7'h00)
     && !(byte_in[7:1] == `GENERAL_CALL_ADDR && general_call_enable))
    |-> !cmp_match)
    else $error("unmasked difference matched");
  AST_MASK_REG: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (sfr_wr_in && sfr_addr_in == `MASK_REG_OFFSET) |=>
    (target_address_mask_and_auto_ack == $past(sfr_wdata_in)))
    else $error("mask register not written");
  AST_READ_BACK: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (sfr_rd_in && sfr_addr_in == `ADDR_REG_OFFSET) |=>
    (sfr_rdata_out == $past(target_address_and_general_call)))
    else $error("address register read wrong");

  // Address byte capture and framing
  AST_ADDR_PHASE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (start_in && !stop_in) |=> (phase == ST_ADDR))
    else $error("start did not open address phase");
  AST_DIR_CAPTURE: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (byte_valid_in && phase == ST_ADDR && !start_in && !stop_in) |=>
    (rw_dir_out == $past(byte_in[0]) && addr_match_out == $past(cmp_match)))
    else $error("address byte capture wrong");
  AST_MATCH_CLEAR: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (start_in || stop_in) |=> !addr_match_out)
    else $error("match flag not cleared");

  // Hardware acknowledge of data bytes follows the address result
  AST_DATA_ACK: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (byte_valid_in && phase == ST_DATA && hardware_ack_enable &&
     !start_in && !stop_in) |=> (ack_valid_out && ack_out == $past(selected)))
    else $error("data ack wrong");
  AST_IDLE_IGNORE: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (byte_valid_in && phase == ST_IDLE && !start_in && !stop_in &&
     !fw_ack_req_out) |=> !ack_valid_out)
    else $error("byte outside frame acknowledged");

  // Firmware acknowledge path: request holds until answered or cut
  AST_FW_ACK: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (fw_ack_req_out && fw_ack_valid_in && !start_in && !stop_in &&
     !(byte_valid_in && phase != ST_IDLE)) |=>
    (ack_valid_out && !fw_ack_req_out && ack_out == $past(fw_ack_in)))
    else $error("firmware decision not passed");
  AST_FW_HOLD: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (fw_ack_req_out && !fw_ack_valid_in && !start_in && !stop_in) |=>
    fw_ack_req_out)
    else $error("firmware request dropped");
  AST_FW_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (start_in || stop_in) |=> !fw_ack_req_out)
    else $error("firmware request not cleared");

  // Main scenarios seen
  COV_HW_ACK: cover property (@(posedge ref_clk_in) ack_valid_out && ack_out);
  COV_NACK: cover property (@(posedge ref_clk_in) ack_valid_out && !ack_out);
  COV_FW_REQ: cover property (@(posedge ref_clk_in) fw_ack_req_out);
  COV_FW_ACK: cover property (@(posedge ref_clk_in)
    fw_ack_req_out && fw_ack_valid_in);
  COV_GC_SEEN: cover property (@(posedge ref_clk_in)
    byte_valid_in && phase == ST_ADDR && byte_in[7:1] == `GENERAL_CALL_ADDR
    && general_call_enable);
endmodule

// File: smbus_master_model.sv
// Bus-side model that frames start, bytes and stop
`timescale 1ns/1ps
module smbus_master_model (
  input wire logic clk_in,
  output logic start_out,
  output logic stop_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out
);
  initial begin
    start_out = 1'b0;
    stop_out = 1'b0;
    byte_valid_out = 1'b0;
    byte_out = 8'hA5;
  end
  // Kind 0 start, 1 byte, 2 stop; one pulse, then a gap cycle
  task automatic drive(input logic [1:0] kind, input logic [7:0] b);
    @(negedge clk_in);
    start_out <= kind == 2'd0;
    byte_valid_out <= kind == 2'd1;
    stop_out <= kind == 2'd2;
    byte_out <= b;
    @(negedge clk_in);
    start_out <= 1'b0;
    byte_valid_out <= 1'b0;
    stop_out <= 1'b0;
    byte_out <= ~b; // Released byte is garbage, never the last value
  endtask
endmodule

// File: test_smbus_slave_address_match.sv
// Self-checking bench for the address match block
`timescale 1ns/1ps
module test_smbus_slave_address_match;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic fw_ack_valid_in = 1'b0;
  logic fw_ack_in = 1'b0;
  logic [7:0] sfr_rdata_out, byte_in;
  logic start_in, stop_in, byte_valid_in;
  logic addr_match_out, ack_valid_out, ack_out, fw_ack_req_out, rw_dir_out;
  int err_total = 0;
  int total_checks = 0;
  // 40 MHz clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  smbus_slave_address_match u_dut (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
    .start_in(start_in), .stop_in(stop_in), .byte_valid_in(byte_valid_in),
    .byte_in(byte_in), .fw_ack_valid_in(fw_ack_valid_in),
    .fw_ack_in(fw_ack_in), .addr_match_out(addr_match_out),
    .ack_valid_out(ack_valid_out), .ack_out(ack_out),
    .fw_ack_req_out(fw_ack_req_out), .rw_dir_out(rw_dir_out));
  smbus_master_model u_bus (.clk_in(ref_clk_in), .start_out(start_in),
    .stop_out(stop_in), .byte_valid_out(byte_valid_in), .byte_out(byte_in));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, s);
    chk8(n, {7'h00, e}, {7'h00, s});
  endtask
  // Register strobes held across one sampling edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(negedge ref_clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge ref_clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(negedge ref_clk_in);
    sfr_rd_in <= 1'b0;
    chk8("sfr_rdata_out", e, sfr_rdata_out);
  endtask
  // Bounded wait for the one-cycle ack pulse
  task automatic wait_ack(input logic e);
    for (int i = 0; i < 4; i++) begin
      if (ack_valid_out === 1'b1) begin
        chk1("ack_out", e, ack_out);
        return;
      end
      @(negedge ref_clk_in);
    end
    err_total++;
    results();
  endtask
  task automatic frame(input logic [7:0] a, input logic e);
    u_bus.drive(2'd0, 8'h00);
    u_bus.drive(2'd1, a);
    wait_ack(e);
    chk1("addr_match_out", e, addr_match_out);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    rd(8'hF4, 8'h00);
    rd(8'hF5, 8'hFE);
    rd(8'h33, 8'h00);
    wr(8'hF4, 8'h84);
    wr(8'hF5, 8'hFF);
    rd(8'hF4, 8'h84);
    frame(8'h85, 1'b1);
    chk1("rw_dir_out", 1'b1, rw_dir_out);
    u_bus.drive(2'd1, 8'h5A);
    wait_ack(1'b1);
    u_bus.drive(2'd2, 8'h00);
    frame(8'h84, 1'b1);
    chk1("rw_dir_out", 1'b0, rw_dir_out);
    frame(8'h87, 1'b0);
    u_bus.drive(2'd1, 8'h5A);
    wait_ack(1'b0);
    frame(8'h00, 1'b0);
    wr(8'hF4, 8'h85);
    frame(8'h00, 1'b1);
    wr(8'hF5, 8'hFD);
    frame(8'h87, 1'b1);
    frame(8'h8D, 1'b0);
    wr(8'hF5, 8'hFC);
    u_bus.drive(2'd0, 8'h00);
    u_bus.drive(2'd1, 8'h85);
    for (int i = 0; i < 4 && fw_ack_req_out !== 1'b1; i++)
      @(negedge ref_clk_in);
    chk1("fw_ack_req_out", 1'b1, fw_ack_req_out);
    chk1("ack_valid_out", 1'b0, ack_valid_out);
    if (fw_ack_req_out !== 1'b1) results();
    fw_ack_valid_in <= 1'b1;
    @(negedge ref_clk_in);
    fw_ack_valid_in <= 1'b0;
    wait_ack(1'b0);
    results();
  end
endmodule
